// file: src/prc_top.sv
`timescale 1ns/1ps
// Operation
// R1: Filter type 0 selects first-order smoothing, 1 selects second-order.
// R2: Filter constant 0..6400 in 0.1 ms, resets to 0, changes live; code adopts a new value only when quiet (R3).
// R3: New filter setting adopted only with no pulses and zero error.
// R4: Host asserts clear to make a new filter setting effective.
// R5: Smoothing reshapes timing only; total pulse count is kept.
// R6: In position mode completion output low when done, else high.
// R7: Completion indication routed to a chosen output terminal.
// R8: Vibration suppression off when its digit is 0, on when 1.
// R9: Vibration suppression works in speed and position modes only.
// R10: Suppression frequency 10..1000 in 0.1 Hz, resets to 1000, live.
// R11: Suppression damping 0..200, resets to 25.
// R12: Suppression need only work for 5.0 to 50.0 Hz vibration.
// R13: Inhibit in position mode stops counting and clamps the motor.
// R14: Inhibit input low means inhibit on, high means normal counting.
// R15: Host holds clear for more than 200 us.
// R16: Host waits over 40 ms after servo on before first pulse.
// R17: Zero filter constant passes pulses unchanged with no delay; code delays them two clocks, three in second order.
module prc_top
  import prc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int CLEAR_CYCLES = CLR_HOLD_CYC
)
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // Host reference and control inputs
  input  wire prc_step_t            ref_i,
  input  wire logic                 pulse_inhibit_n_i,
  input  wire logic                 position_error_clear_i,
  input  wire logic                 servo_on_i,
  input  wire prc_mode_t            ctrl_mode_i,
  // Motor feedback
  input  wire prc_step_t            fb_i,
  // Drive side outputs
  output prc_step_t                 cmd_o,
  output logic signed [15:0]        vib_comp_o,
  output logic                      clamp_o,
  output logic [NUM_TERM-1:0]       out_term_n_o
);

  // Software registers
  prc_filt_t               filt_reg_ff;
  prc_filt_t               filt_act_ff;
  prc_vib_t                vib_reg_ff;
  logic [1:0]              assign_ff;
  logic [15:0]             width_ff;
  // Bus answer
  logic                    ack_ff;
  logic [31:0]             rdat_ff;
  // Core state
  prc_adopt_t              adopt_ff;
  prc_adopt_t              nxt_adopt;
  logic [15:0]             tick_cnt_ff;
  logic [15:0]             clr_cnt_ff;
  logic signed [ERR_W-1:0] err_ff;
  logic signed [15:0]      inc_ff;
  logic signed [15:0]      inc_smp_ff;
  prc_step_t               cmd_ff;
  logic                    clamp_ff;
  logic [NUM_TERM-1:0]     term_ff;
  // Stage links
  prc_step_t               lag1_out;
  prc_step_t               lag2_out;
  logic                    lag1_busy;
  logic                    lag2_busy;
  logic signed [15:0]      vib_comp;

  // Bus decode and byte lane merge
  wire        req_w   = wb_cyc_i && wb_stb_i && !ack_ff;
  wire        wr_w    = req_w && wb_we_i;
  wire [31:0] mask_w  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        wr_ctrl = wr_w && (wb_adr_i == ADR_CTRL);
  wire        wr_tc   = wr_w && (wb_adr_i == ADR_TC);
  wire        wr_freq = wr_w && (wb_adr_i == ADR_FREQ);
  wire        wr_damp = wr_w && (wb_adr_i == ADR_DAMP);
  wire        wr_asg  = wr_w && (wb_adr_i == ADR_ASSIGN);
  wire        wr_wid  = wr_w && (wb_adr_i == ADR_WIDTH);

  // Current register words for merging
  wire [31:0] ctrl_cur = {30'h0, vib_reg_ff.en, filt_reg_ff.second};
  wire [31:0] tc_cur   = {19'h0, filt_reg_ff.tc};
  wire [31:0] freq_cur = {22'h0, vib_reg_ff.freq};
  wire [31:0] damp_cur = {24'h0, vib_reg_ff.damp};
  wire [31:0] asg_cur  = {30'h0, assign_ff};
  wire [31:0] wid_cur  = {16'h0, width_ff};
  wire [31:0] ctrl_new = (ctrl_cur & ~mask_w) | (wb_dat_i & mask_w);
  wire [31:0] tc_new   = (tc_cur & ~mask_w) | (wb_dat_i & mask_w);
  wire [31:0] freq_new = (freq_cur & ~mask_w) | (wb_dat_i & mask_w);
  wire [31:0] damp_new = (damp_cur & ~mask_w) | (wb_dat_i & mask_w);
  wire [31:0] asg_new  = (asg_cur & ~mask_w) | (wb_dat_i & mask_w);
  wire [31:0] wid_new  = (wid_cur & ~mask_w) | (wb_dat_i & mask_w);

  // Range clamps on written settings
  wire [12:0] tc_lim   = (tc_new > {19'h0, TC_MAX}) ? TC_MAX : tc_new[12:0];  // see R2
  wire [9:0]  freq_lim = (freq_new > {22'h0, FREQ_MAX}) ? FREQ_MAX :
                         (freq_new < {22'h0, FREQ_MIN}) ? FREQ_MIN :
                         freq_new[9:0];  // see R10
  wire [7:0]  damp_lim = (damp_new > {24'h0, DAMP_MAX}) ? DAMP_MAX :
                         damp_new[7:0];  // see R11

  // Mode and reference qualification
  wire        pos_w    = (ctrl_mode_i == MODE_POS);
  wire        inhib_w  = pos_w && !pulse_inhibit_n_i;  // see R14
  wire        take_w   = pos_w && servo_on_i && pulse_inhibit_n_i && ref_i.step;  // see R13
  wire        tick_w   = (tick_cnt_ff == 16'(TICK_CYCLES - 1));
  wire        clr_w    = (clr_cnt_ff == 16'(CLEAR_CYCLES - 1));  // see R15
  wire        busy_w   = lag1_busy || lag2_busy;
  wire        vib_en_w = vib_reg_ff.en && (ctrl_mode_i != MODE_TORQUE);  // see R9

  // Filter staging and final command
  wire prc_step_t in1_w   = prc_step_t'{step: take_w, fwd: ref_i.fwd};
  wire prc_step_t in2_w   = filt_act_ff.second ? lag1_out : prc_step_t'(2'b00);
  wire prc_step_t final_w = filt_act_ff.second ? lag2_out : lag1_out;  // see R1

  // Position error: command minus feedback
  wire signed [ERR_W-1:0] cmd_v = !cmd_ff.step ? '0 : cmd_ff.fwd ? 24'sd1 : -24'sd1;
  wire signed [ERR_W-1:0] fb_v  = !fb_i.step ? '0 : fb_i.fwd ? 24'sd1 : -24'sd1;
  wire [ERR_W-1:0]        err_mag = err_ff[ERR_W-1] ? 24'(-err_ff) : 24'(err_ff);

  // Completion: reference drained and error inside window
  wire done_w = pos_w && !busy_w && !cmd_ff.step &&
                (err_mag <= {8'h00, width_ff});  // see R6

  // Quiet condition for adopting new filter settings
  wire quiet_w = !ref_i.step && (err_ff == '0) && !busy_w && !cmd_ff.step;  // see R3

  // Read mux
  wire [31:0] stat_w = {27'h0, busy_w, filt_act_ff.second,
                        (adopt_ff != ST_RUN), inhib_w, done_w};
  wire [31:0] rd_w   = (wb_adr_i == ADR_CTRL)   ? ctrl_cur :
                       (wb_adr_i == ADR_TC)     ? tc_cur :
                       (wb_adr_i == ADR_FREQ)   ? freq_cur :
                       (wb_adr_i == ADR_DAMP)   ? damp_cur :
                       (wb_adr_i == ADR_ASSIGN) ? asg_cur :
                       (wb_adr_i == ADR_WIDTH)  ? wid_cur :
                       (wb_adr_i == ADR_STATUS) ? stat_w :
                       (wb_adr_i == ADR_ERR)    ? {{8{err_ff[ERR_W-1]}}, err_ff} :
                       32'h00000000;

  // Bus answer one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff  <= req_w;
      rdat_ff <= req_w ? rd_w : 32'h00000000;
    end
  end

  // Software settings; vibration values apply at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      filt_reg_ff <= prc_filt_t'{second: 1'b0, tc: TC_RST};
      vib_reg_ff  <= prc_vib_t'{en: 1'b0, freq: FREQ_RST, damp: DAMP_RST};
      assign_ff   <= ASSIGN_RST;
      width_ff    <= WIDTH_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        filt_reg_ff.second <= ctrl_new[CTRL_SECOND_BIT];
        vib_reg_ff.en      <= ctrl_new[CTRL_VIB_BIT];  // see R8
      end
      if (wr_tc)
        filt_reg_ff.tc <= tc_lim;
      if (wr_freq)
        vib_reg_ff.freq <= freq_lim;
      if (wr_damp)
        vib_reg_ff.damp <= damp_lim;
      if (wr_asg)
        assign_ff <= asg_new[1:0];
      if (wr_wid)
        width_ff <= wid_new[15:0];
    end
  end

  // Adoption sequencer for filter settings
  always_comb
  begin
    nxt_adopt = adopt_ff;
    case (adopt_ff)
      ST_RUN:
        if (filt_reg_ff != filt_act_ff)
          nxt_adopt = ST_WAIT;
      ST_WAIT:
        if (quiet_w)
          nxt_adopt = ST_LOAD;  // see R3
      ST_LOAD:
        nxt_adopt = ST_RUN;
      default:
        nxt_adopt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      adopt_ff    <= ST_RUN;
      filt_act_ff <= prc_filt_t'{second: 1'b0, tc: TC_RST};
    end
    else
    begin
      adopt_ff <= nxt_adopt;
      if (adopt_ff == ST_LOAD)
        filt_act_ff <= filt_reg_ff;  // see R2
    end
  end

  // Filter step timer
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick_w)
      tick_cnt_ff <= 16'h0000;
    else
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
  end

  // Clear must be held long enough to register
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !position_error_clear_i)
      clr_cnt_ff <= 16'h0000;
    else if (!clr_w)
      clr_cnt_ff <= clr_cnt_ff + 16'h0001;  // see R15
  end

  // Error counter; a held clear zeroes it  // see R4
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr_w)
      err_ff <= '0;
    else
      err_ff <= err_ff + cmd_v - fb_v;
  end

  // Per-step command increment feeding the load model
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      inc_ff     <= 16'sh0000;
      inc_smp_ff <= 16'sh0000;
    end
    else if (tick_w)
    begin
      inc_ff     <= 16'(cmd_v);
      inc_smp_ff <= inc_ff;
    end
    else
      inc_ff <= inc_ff + 16'(cmd_v);
  end

  // Registered drive outputs and terminal routing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_ff   <= '0;
      clamp_ff <= 1'b0;
      term_ff  <= '1;
    end
    else
    begin
      cmd_ff   <= final_w;
      clamp_ff <= inhib_w;  // see R13
      for (int i = 0; i < NUM_TERM; i++)
        term_ff[i] <= !(done_w && (assign_ff == 2'(i)));  // see R7
    end
  end

  // First smoothing stage
  prc_lag u_lag1 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .flush_i (clr_w),
    .tick_i  (tick_w),
    .tc_i    (filt_act_ff.tc),
    .in_i    (in1_w),
    .out_o   (lag1_out),
    .busy_o  (lag1_busy)
  );

  // Second stage, fed only in second-order mode
  prc_lag u_lag2 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .flush_i (clr_w),
    .tick_i  (tick_w),
    .tc_i    (filt_act_ff.tc),
    .in_i    (in2_w),
    .out_o   (lag2_out),
    .busy_o  (lag2_busy)
  );

  // Load vibration model; tuned for 5..50 Hz loads  // see R12
  prc_vib u_vib (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (tick_w),
    .en_i   (vib_en_w),
    .set_i  (vib_reg_ff),
    .inc_i  (inc_smp_ff),
    .comp_o (vib_comp)
  );

  assign wb_ack_o     = ack_ff;
  assign wb_dat_o     = rdat_ff;
  assign cmd_o        = cmd_ff;
  assign vib_comp_o   = vib_comp;
  assign clamp_o      = clamp_ff;
  assign out_term_n_o = term_ff;

endmodule // prc_top

// file: src/prc_pkg.sv
package prc_pkg;

  // Clock and timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int CLK_PER_US   = CLK_HZ / 1_000_000;
  localparam int TICK_NS      = 100_000;  // 0.1 ms filter step
  localparam int TICK_CYC     = (TICK_NS * CLK_PER_US + 999) / 1000;
  localparam int CLR_HOLD_US  = 200;      // least clear width
  localparam int CLR_HOLD_CYC = CLR_HOLD_US * CLK_PER_US;

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_TC     = 8'h04;
  localparam logic [7:0] ADR_FREQ   = 8'h08;
  localparam logic [7:0] ADR_DAMP   = 8'h0C;
  localparam logic [7:0] ADR_ASSIGN = 8'h10;
  localparam logic [7:0] ADR_WIDTH  = 8'h14;
  localparam logic [7:0] ADR_STATUS = 8'h18;
  localparam logic [7:0] ADR_ERR    = 8'h1C;

  // Field positions
  localparam int CTRL_SECOND_BIT = 0;
  localparam int CTRL_VIB_BIT    = 1;
  localparam int STAT_DONE_BIT   = 0;
  localparam int STAT_INHIB_BIT  = 1;
  localparam int STAT_PEND_BIT   = 2;
  localparam int STAT_SECOND_BIT = 3;
  localparam int STAT_BUSY_BIT   = 4;

  // Reset values and limits
  localparam logic [12:0] TC_RST     = 13'h0000;
  localparam logic [12:0] TC_MAX     = 13'h1900;  // 6400
  localparam logic [9:0]  FREQ_RST   = 10'h3E8;   // 1000
  localparam logic [9:0]  FREQ_MIN   = 10'h00A;   // 10
  localparam logic [9:0]  FREQ_MAX   = 10'h3E8;   // 1000
  localparam logic [7:0]  DAMP_RST   = 8'h19;     // 25
  localparam logic [7:0]  DAMP_MAX   = 8'hC8;     // 200
  localparam logic [1:0]  ASSIGN_RST = 2'h0;
  localparam logic [15:0] WIDTH_RST  = 16'h000A;
  localparam int          ERR_W      = 24;
  localparam int          NUM_TERM   = 4;

  typedef enum logic [1:0] {
    MODE_SPEED  = 2'b00,
    MODE_POS    = 2'b01,
    MODE_TORQUE = 2'b11
  } prc_mode_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_WAIT = 2'b01,
    ST_LOAD = 2'b11
  } prc_adopt_t;

  typedef struct packed {
    logic step;
    logic fwd;
  } prc_step_t;

  typedef struct packed {
    logic        second;
    logic [12:0] tc;
  } prc_filt_t;

  typedef struct packed {
    logic       en;
    logic [9:0] freq;
    logic [7:0] damp;
  } prc_vib_t;

endpackage

// file: src/prc_lag.sv
`timescale 1ns/1ps
module prc_lag
  import prc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Control
  input  wire logic        flush_i,
  input  wire logic        tick_i,
  input  wire logic [12:0] tc_i,
  // Pulse stream
  input  wire prc_step_t   in_i,
  output prc_step_t        out_o,
  output logic             busy_o
);

  logic signed [ERR_W-1:0] pend_ff;
  logic [31:0]             acc_ff;
  prc_step_t               out_ff;
  logic signed [ERR_W-1:0] nxt_pend;
  logic [31:0]             nxt_acc;

  // Pending count and release decision
  wire                     pass_w = (tc_i == 13'h0000);
  wire signed [ERR_W-1:0]  in_v   = !in_i.step ? '0 : in_i.fwd ? 24'sd1 : -24'sd1;
  wire                     neg_w  = pend_ff[ERR_W-1];
  wire [31:0]              mag_w  = 32'(neg_w ? -pend_ff : pend_ff);
  wire [31:0]              tc_w   = {19'h00000, tc_i};
  wire                     emit_w = !pass_w && (pend_ff != '0) && (acc_ff >= tc_w);
  wire signed [ERR_W-1:0]  out_v  = !emit_w ? '0 : neg_w ? -24'sd1 : 24'sd1;
  wire [31:0]              add_w  = tick_i ? mag_w : 32'h00000000;
  wire [31:0]              sub_w  = emit_w ? tc_w : 32'h00000000;

  // Released pulses drain the pending count; a flush zeroes it  // see R5
  assign nxt_pend = (flush_i || pass_w) ? '0 : pend_ff + in_v - out_v;
  assign nxt_acc  = (flush_i || pend_ff == '0) ? 32'h00000000 : acc_ff + add_w - sub_w;

  // Zero constant passes pulses on unchanged, one clock later  // see R17
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_ff <= '0;
      acc_ff  <= 32'h00000000;
      out_ff  <= '0;
    end
    else
    begin
      pend_ff <= nxt_pend;
      acc_ff  <= nxt_acc;
      out_ff  <= pass_w ? in_i : prc_step_t'{step: emit_w, fwd: !neg_w};
    end
  end

  assign out_o  = out_ff;
  assign busy_o = (pend_ff != '0) || out_ff.step;

endmodule // prc_lag

// file: src/prc_vib.sv
`timescale 1ns/1ps
module prc_vib
  import prc_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Control
  input  wire logic               tick_i,
  input  wire logic               en_i,
  input  wire prc_vib_t           set_i,
  // Load model drive and output
  input  wire logic signed [15:0] inc_i,
  output logic signed [15:0]      comp_o
);

  logic signed [31:0] low_ff;
  logic signed [31:0] band_ff;

  // Resonator coefficients, Q16 frequency and Q8 damping
  wire signed [15:0]  f_w  = {4'h0, set_i.freq, 2'b00};
  wire signed [15:0]  q_w  = {7'h00, set_i.damp, 1'b0} + {9'h000, set_i.damp[7:1]};
  wire signed [31:0]  in_w = {inc_i, 16'h0000};
  wire signed [47:0]  qb_w = band_ff * q_w;
  wire signed [31:0]  hp_w = in_w - low_ff - 32'(qb_w >>> 8);
  wire signed [47:0]  fh_w = f_w * hp_w;
  wire signed [47:0]  fb_w = f_w * band_ff;

  // Load position estimate, cleared while disabled  // see R8
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !en_i)
    begin
      low_ff  <= 32'sh00000000;
      band_ff <= 32'sh00000000;
    end
    else if (tick_i)
    begin
      band_ff <= band_ff + 32'(fh_w >>> 16);
      low_ff  <= low_ff + 32'(fb_w >>> 16);
    end
  end

  assign comp_o = band_ff[31:16];

endmodule // prc_vib

// file: testbench/prc_top_monitor.sv
`timescale 1ns/1ps
module prc_top_monitor
  import prc_pkg::*;
#(
  parameter int TICK_CYCLES  = TICK_CYC,
  parameter int CLEAR_CYCLES = CLR_HOLD_CYC
)
(
  // Clock and reset
  input wire logic                clk_i,
  input wire logic                rst_i,
  // Bus
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  // Control and drive side
  input wire logic                pulse_inhibit_n_i,
  input wire prc_mode_t           ctrl_mode_i,
  input wire prc_step_t           cmd_o,
  input wire logic signed [15:0]  vib_comp_o,
  input wire logic                clamp_o,
  input wire logic [NUM_TERM-1:0] out_term_n_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Bus handshake
  chk_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero outside ack");
  // Quiet outputs at the edge after reset
  chk_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
    $past(rst_i) |-> cmd_o == '0 && !clamp_o && &out_term_n_o)
    else $error("outputs active right after reset");
  // Clamp, completion and suppression gating
  chk_clamp_follow: assert property (!$past(rst_i) |->
    clamp_o == $past(ctrl_mode_i == MODE_POS && !pulse_inhibit_n_i))
    else $error("clamp does not follow inhibit");
  chk_term_needs_pos: assert property (!$past(rst_i) && $past(ctrl_mode_i) != MODE_POS
    |-> &out_term_n_o)
    else $error("completion shown outside position mode");
  chk_term_single: assert property ($countones(~out_term_n_o) <= 1)
    else $error("completion on more than one terminal");
  chk_vib_torque_zero: assert property ($past(ctrl_mode_i) == MODE_TORQUE &&
    $past(ctrl_mode_i, 2) == MODE_TORQUE |-> vib_comp_o == '0)
    else $error("suppression active in torque mode");

  // Main scenarios
  cov_clamped: cover property (clamp_o);
  cov_burst: cover property (cmd_o.step ##1 cmd_o.step);
  cov_term_two: cover property (!out_term_n_o[2]);
  cov_vib_active: cover property (vib_comp_o != '0);
endmodule // prc_top_monitor

// file: testbench/prc_host.sv
`timescale 1ns/1ps
module prc_host
  import prc_pkg::*;
#(
  parameter int ON_WAIT = 40
)
(
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  // Burst request
  input  wire logic      go_i,
  input  wire logic      fwd_i,
  input  wire logic      fb_en_i,
  // Drive side
  input  wire prc_step_t cmd_i,
  output prc_step_t      ref_o,
  output prc_step_t      fb_o,
  output logic           servo_on_o,
  output logic           ready_o
);
  int wait_ff;

  // Servo on first, pulses only after the settle wait
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wait_ff    <= 0;
      servo_on_o <= 1'b0;
    end
    else
    begin
      servo_on_o <= 1'b1;
      if (wait_ff < ON_WAIT) wait_ff <= wait_ff + 1;
    end
  end

  // One pulse per cycle while go is held; motor echoes the command
  assign ready_o = (wait_ff == ON_WAIT);
  assign ref_o   = '{step: go_i & ready_o, fwd: fwd_i};
  assign fb_o    = fb_en_i ? cmd_i : '0;
endmodule // prc_host

// file: testbench/test_position_reference_conditioning.sv
`timescale 1ns/1ps
module test_position_reference_conditioning
  import prc_pkg::*;
();
  localparam int TK  = 20;
  localparam int CLR = 8;
  logic               clk_i, rst_i, req, we, clr, inh_n, go, fwd, fb_en, son, rdy, ack, clamp;
  logic [7:0]         adr;
  logic [31:0]        dat, dat_o, q;
  logic [3:0]         term, sel;
  logic signed [15:0] vib;
  prc_mode_t          mode;
  prc_step_t          ref_s, fb, cmd;
  int                 miscompares, checked, cmd_sum, s, vib_hits;

  // Device and host
  prc_top #(.TICK_CYCLES(TK), .CLEAR_CYCLES(CLR)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ref_i(ref_s), .pulse_inhibit_n_i(inh_n), .position_error_clear_i(clr),
    .servo_on_i(son), .ctrl_mode_i(mode), .fb_i(fb), .cmd_o(cmd), .vib_comp_o(vib),
    .clamp_o(clamp), .out_term_n_o(term));
  prc_host i_host (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .fwd_i(fwd), .fb_en_i(fb_en),
    .cmd_i(cmd), .ref_o(ref_s), .fb_o(fb), .servo_on_o(son), .ready_o(rdy));

  // Clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Signed tally of command pulses
  always @(posedge clk_i)
    if (cmd.step === 1'b1) cmd_sum += (cmd.fwd === 1'b1) ? 1 : -1;

  // Cycles with any suppression output after reset
  always @(posedge clk_i)
    if (rst_i === 1'b0 && vib !== 16'sh0000) vib_hits++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One classic bus cycle, released after ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o;
    if (n >= 50) chk(0, 1);
    req <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do
    begin
      wb(1'b0, ADR_STATUS, 32'h0);
      n++;
    end while ((q & m) !== e && n < 100);
    chk(q & m, e);
  endtask

  task automatic burst(input int n, input logic f);
    fwd <= f;
    go <= 1'b1;
    repeat (n) @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
  endtask

  // Reset values, unmapped read, clamped writes
  task automatic t_regs();
    rdm(ADR_CTRL, '1, 32'h0);
    rdm(ADR_TC, '1, 32'h0);
    rdm(ADR_FREQ, '1, 32'h3E8);
    rdm(ADR_DAMP, '1, 32'h19);
    rdm(8'h20, '1, 32'h0);
    wb(1'b1, ADR_TC, 32'h1B58);
    rdm(ADR_TC, '1, 32'h1900);
    wb(1'b1, ADR_FREQ, 32'h5);
    rdm(ADR_FREQ, '1, 32'hA);
    wb(1'b1, ADR_FREQ, 32'h7D0);
    rdm(ADR_FREQ, '1, 32'h3E8);
    wb(1'b1, ADR_DAMP, 32'h12C);
    rdm(ADR_DAMP, '1, 32'hC8);
    sel <= 4'h2;
    wb(1'b1, ADR_WIDTH, 32'h00003300);
    sel <= 4'hF;
    rdm(ADR_WIDTH, '1, 32'h330A);
    wb(1'b1, ADR_WIDTH, 32'hA);
    wb(1'b1, ADR_TC, 32'h0);
    poll(32'h4, 32'h0);
  endtask

  // Zero constant passes pulses through unchanged, two clocks late
  task automatic t_pass();
    s = cmd_sum;
    fwd <= 1'b1;
    go <= 1'b1;
    @(posedge clk_i);
    #1 chk(cmd.step, 0);
    @(posedge clk_i);
    #1 chk(cmd.step, 1);
    repeat (3) @(posedge clk_i);
    go <= 1'b0;
    poll(32'h11, 32'h1);
    chk(cmd_sum - s, 5);
    chk(term, 32'hE);
    rdm(ADR_ERR, '1, 32'h0);
  endtask

  // Change held off by error, clear adopts second order
  task automatic t_adopt();
    fb_en <= 1'b0;
    burst(3, 1'b1);
    repeat (5) @(posedge clk_i);
    rdm(ADR_ERR, '1, 32'h3);
    wb(1'b1, ADR_CTRL, 32'h1);
    wb(1'b1, ADR_TC, 32'h2);
    rdm(ADR_STATUS, 32'hC, 32'h4);
    clr <= 1'b1;
    repeat (CLR + 2) @(posedge clk_i);
    clr <= 1'b0;
    fb_en <= 1'b1;
    poll(32'hC, 32'h8);
    rdm(ADR_ERR, '1, 32'h0);
    s = cmd_sum;
    burst(20, 1'b0);
    poll(32'h11, 32'h1);
    chk(cmd_sum - s, -20);
  endtask

  // Inhibit stops counting
  task automatic t_inhibit();
    inh_n <= 1'b0;
    s = cmd_sum;
    burst(4, 1'b1);
    repeat (10) @(posedge clk_i);
    chk(cmd_sum - s, 0);
    chk(clamp, 1);
    rdm(ADR_STATUS, 32'h2, 32'h2);
    inh_n <= 1'b1;
    burst(2, 1'b1);
    poll(32'h11, 32'h1);
    chk(cmd_sum - s, 2);
    chk(clamp, 0);
  endtask

  // Terminal routing and mode gating
  task automatic t_term();
    wb(1'b1, ADR_ASSIGN, 32'h2);
    poll(32'h1, 32'h1);
    chk(term, 32'hB);
    chk(vib, 32'h0);
    mode <= MODE_SPEED;
    repeat (3) @(posedge clk_i);
    chk(term, 32'hF);
    mode <= MODE_POS;
    wb(1'b1, ADR_CTRL, 32'h3);
    wb(1'b1, ADR_DAMP, 32'h19);
    chk(vib_hits, 0);
    s = cmd_sum;
    burst(60, 1'b1);
    poll(32'h11, 32'h1);
    chk(cmd_sum - s, 60);
    chk(vib_hits != 0, 1);
    mode <= MODE_TORQUE;
    burst(5, 1'b1);
    repeat (2) @(posedge clk_i);
    chk(vib, 32'h0);
  endtask

  task automatic summarize();
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (50000) @(posedge clk_i);
    miscompares++;
    summarize();
  end

  // Main sequence
  initial
  begin
    {req, we, clr, go, fwd, fb_en, adr, dat} = '0;
    {miscompares, checked, cmd_sum, vib_hits} = '0;
    sel = 4'hF;
    inh_n = 1'b1;
    mode = MODE_POS;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    fb_en <= 1'b1;
    wait (rdy === 1'b1);
    @(posedge clk_i);
    t_regs();
    t_pass();
    t_adopt();
    t_inhibit();
    t_term();
    summarize();
  end
endmodule // test_position_reference_conditioning

bind prc_top prc_top_monitor #(.TICK_CYCLES(TICK_CYCLES), .CLEAR_CYCLES(CLEAR_CYCLES)) i_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pulse_inhibit_n_i(pulse_inhibit_n_i),
  .ctrl_mode_i(ctrl_mode_i), .cmd_o(cmd_o), .vib_comp_o(vib_comp_o), .clamp_o(clamp_o),
  .out_term_n_o(out_term_n_o));
